//--- rtl/flpls_prot.sv
// protection status, sector lock array and pointer zone guard of a serial flash
// Notes on behaviour
// R1: lock status is volatile read-only, two read paths
// R2: config lock 0 blocks pointer zone changes
// R3: lock status set command sets config lock
// R4: config lock at bit0, reset from otp bits
// R5: bit6 reports region3 read password mode
// R6: 8-bit view mirrors addressed sector lock
// R7: lock commands make sector read 00h, protected
// R8: unlock commands make sector read FFh, open
// R9: boot lock bit chooses sector reset state
// R10: pointer zone written by set or write-any
// R11: guard-all field at bit 11 protects everything
// R12: direction bit 9: 0 top, 1 bottom
// R13: boundary from bits 23..12, plus 24 wide
// R14: pointer zone active only when bit 10 is 0
// R15: host addresses sector, wide form beyond 24 bits
`timescale 1ns/1ps
module flpls_prot
	import flpls_pkg::*;
#(
	parameter bit WIDE_DENSITY = 1'b1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire flpls_cmd_type cmd_in,
	input wire logic [15:0] otp_guard_config_in,
	input wire logic chk_valid_in,
	input wire logic [31:0] chk_addr_in,
	output logic rd_valid_out,
	output logic [31:0] rd_data_out,
	output logic chk_done_out,
	output logic chk_blocked_out,
	output logic config_lock_out
);
	flpls_state_type state_reg;
	flpls_state_type state_next;

	logic wide_op;
	logic [31:0] cmd_addr_eff;
	logic [SECTOR_IDX_W-1:0] cmd_sector;
	logic [SECTOR_IDX_W-1:0] chk_sector;
	logic [7:0] lock_status_view;
	logic [7:0] sector_view;
	logic [31:0] pointer_write_value;
	logic pointer_write_req;
	logic [PZ_ADDR_HI:PZ_ADDR_LO] boundary;
	logic [PZ_ADDR_HI:PZ_ADDR_LO] chk_page;
	logic pointer_hit;
	logic boot_locked;
	logic reset_config_lock;

	// address form and sector selection
	always_comb begin
		wide_op = (cmd_in.opcode == OP_SECTOR_LOCK_READ_WIDE) || (cmd_in.opcode == OP_SECTOR_LOCK_WIDE) ||
			(cmd_in.opcode == OP_SECTOR_UNLOCK_WIDE) || (cmd_in.opcode == OP_POINTER_SET_WIDE);
		cmd_addr_eff = wide_op ? cmd_in.addr : (cmd_in.addr & NARROW_ADDR_MASK); // [R15]
		cmd_sector = cmd_addr_eff[SECTOR_SHIFT +: SECTOR_IDX_W];
		chk_sector = chk_addr_in[SECTOR_SHIFT +: SECTOR_IDX_W];
	end

	// read views of lock status and the sector lock array
	always_comb begin
		lock_status_view = 8'h00;
		lock_status_view[LS_CONFIG_LOCK_POS] = state_reg.config_lock; // [R4]
		lock_status_view[LS_RD_PW_MODE_POS] = otp_guard_config_in[OTP_RD_PW_POS]; // [R5]
		sector_view = state_reg.sector_lock[cmd_sector] ? SECTOR_OPEN : SECTOR_LOCKED; // [R6]
	end

	// reset values taken from the otp configuration
	always_comb begin
		boot_locked = otp_guard_config_in[OTP_BOOT_LOCK_POS];
		reset_config_lock = otp_guard_config_in[OTP_PASSWORD_POS] & otp_guard_config_in[OTP_PERM_POS]; // [R4]
	end

	// pointer zone write source, reserved high bit forced to 1 on narrow parts
	always_comb begin
		pointer_write_req = 1'b0;
		pointer_write_value = cmd_in.wdata;
		if (cmd_in.valid) begin
			if ((cmd_in.opcode == OP_POINTER_SET) || (cmd_in.opcode == OP_POINTER_SET_WIDE)) begin
				pointer_write_req = 1'b1; // [R10]
				pointer_write_value = cmd_addr_eff;
			end else if ((cmd_in.opcode == OP_WRITE_ANY_REG) && (cmd_in.addr == ADDR_POINTER_ZONE)) begin
				pointer_write_req = 1'b1; // [R10]
			end
		end
		if (!WIDE_DENSITY) begin
			pointer_write_value[PZ_ADDR_HI] = 1'b1; // [R13]
		end
	end

	// pointer zone region test for the checked address
	always_comb begin
		boundary = state_reg.pointer_zone_guard[PZ_ADDR_HI:PZ_ADDR_LO]; // [R13]
		chk_page = chk_addr_in[PZ_ADDR_HI:PZ_ADDR_LO];
		if (!WIDE_DENSITY) begin
			boundary[PZ_ADDR_HI] = 1'b0;
			chk_page[PZ_ADDR_HI] = 1'b0;
		end
		pointer_hit = 1'b0;
		if (!state_reg.pointer_zone_guard[PZ_ENABLE_POS]) begin // [R14]
			if (state_reg.pointer_zone_guard[PZ_ALL_POS]) begin
				pointer_hit = 1'b1; // [R11]
			end else if (!state_reg.pointer_zone_guard[PZ_DIRECTION_POS]) begin
				pointer_hit = (chk_page >= boundary); // [R12]
			end else begin
				pointer_hit = (chk_page <= boundary); // [R12]
			end
		end
	end

	// next state: commands, reads and protection checks
	always_comb begin
		state_next = state_reg;
		state_next.rd_valid = 1'b0;
		state_next.chk_done = chk_valid_in;
		if (chk_valid_in) begin
			state_next.chk_blocked = !state_reg.sector_lock[chk_sector] || pointer_hit; // [R7] [R8]
		end
		if (cmd_in.valid) begin
			unique case (cmd_in.opcode)
				OP_LOCK_STATUS_READ: begin
					state_next.rd_valid = 1'b1;
					state_next.rd_data = {24'h000000, lock_status_view}; // [R1]
				end
				OP_LOCK_STATUS_SET: begin
					state_next.config_lock = 1'b1; // [R3]
				end
				OP_READ_ANY_REG: begin
					state_next.rd_valid = 1'b1;
					if (cmd_in.addr == ADDR_LOCK_STATUS) begin
						state_next.rd_data = {24'h000000, lock_status_view}; // [R1]
					end else if (cmd_in.addr == ADDR_POINTER_ZONE) begin
						state_next.rd_data = state_reg.pointer_zone_guard;
					end else begin
						state_next.rd_data = 32'h0000_0000;
					end
				end
				OP_SECTOR_LOCK_READ, OP_SECTOR_LOCK_READ_WIDE: begin
					state_next.rd_valid = 1'b1;
					state_next.rd_data = {24'h000000, sector_view}; // [R6]
				end
				OP_SECTOR_LOCK, OP_SECTOR_LOCK_WIDE: begin
					state_next.sector_lock[cmd_sector] = 1'b0; // [R7]
				end
				OP_SECTOR_UNLOCK, OP_SECTOR_UNLOCK_WIDE: begin
					state_next.sector_lock[cmd_sector] = 1'b1; // [R8]
				end
				OP_GLOBAL_LOCK: begin
					state_next.sector_lock = '0; // [R7]
				end
				OP_GLOBAL_UNLOCK: begin
					state_next.sector_lock = '1; // [R8]
				end
				default: begin
					// write-any to the lock status address has no effect
				end
			endcase
		end
		if (pointer_write_req && state_reg.config_lock) begin
			state_next.pointer_zone_guard = pointer_write_value; // [R2] [R10]
		end
		if (!rstn_in) begin
			state_next = '0;
			state_next.config_lock = reset_config_lock; // [R4]
			state_next.sector_lock = boot_locked ? '0 : '1; // [R9]
			state_next.pointer_zone_guard = PZ_RESET; // [R13]
		end
	end

	// state register, synchronous reset folded into next state
	always_ff @(posedge clk_in) begin
		state_reg <= state_next;
	end

	// outputs straight from state
	always_comb begin
		rd_valid_out = state_reg.rd_valid;
		rd_data_out = state_reg.rd_data;
		chk_done_out = state_reg.chk_done;
		chk_blocked_out = state_reg.chk_blocked;
		config_lock_out = state_reg.config_lock;
	end

	// named steps of a lock then read sequence
	sequence s_lock_cmd;
		cmd_in.valid && ((cmd_in.opcode == OP_SECTOR_LOCK) || (cmd_in.opcode == OP_GLOBAL_LOCK));
	endsequence
	sequence s_read_back;
		cmd_in.valid && (cmd_in.opcode == OP_SECTOR_LOCK_READ) && (cmd_in.addr == $past(cmd_in.addr));
	endsequence

	a_ls_read_view: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1]
		cmd_in.valid && (cmd_in.opcode == OP_LOCK_STATUS_READ) |=> rd_valid_out && (rd_data_out[31:8] == 24'h0)
			&& (rd_data_out[7:1] == {1'b0, $past(otp_guard_config_in[OTP_RD_PW_POS]), 5'b0})
			&& (rd_data_out[0] == $past(config_lock_out)))
		else $error("lock status read wrong");
	a_ptr_guarded: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R2]
		pointer_write_req && !config_lock_out |=> $stable(state_reg.pointer_zone_guard))
		else $error("pointer zone changed while config locked");
	a_set_cmd_lock: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R3]
		cmd_in.valid && (cmd_in.opcode == OP_LOCK_STATUS_SET) |=> config_lock_out)
		else $error("lock status set did not set config lock");
	a_lock_only_rises: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R4]
		$past(rstn_in) |-> !$fell(config_lock_out))
		else $error("config lock fell outside reset");
	a_pw_mode_bit: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R5]
		cmd_in.valid && (cmd_in.opcode == OP_READ_ANY_REG) && (cmd_in.addr == ADDR_LOCK_STATUS)
			|=> rd_data_out[LS_RD_PW_MODE_POS] == $past(otp_guard_config_in[OTP_RD_PW_POS]))
		else $error("read password mode bit wrong");
	a_lock_reads_zero: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7]
		s_lock_cmd ##1 s_read_back |=> rd_valid_out && (rd_data_out[7:0] == SECTOR_LOCKED))
		else $error("locked sector did not read 00h");
	a_unlock_reads_ff: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R8]
		cmd_in.valid && (cmd_in.opcode == OP_GLOBAL_UNLOCK) ##1 cmd_in.valid
			&& (cmd_in.opcode == OP_SECTOR_LOCK_READ) |=> rd_data_out[7:0] == SECTOR_OPEN)
		else $error("unlocked sector did not read FFh");
	a_boot_state: assert property (@(posedge clk_in) // [R9]
		!rstn_in |=> (state_reg.sector_lock == {SECTOR_COUNT{!$past(boot_locked)}}))
		else $error("sector lock reset state wrong");
	a_ptr_written: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R10]
		pointer_write_req && config_lock_out && WIDE_DENSITY
			|=> state_reg.pointer_zone_guard == $past(pointer_write_value))
		else $error("pointer zone write lost");
	a_guard_all: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R11] [R14]
		chk_valid_in && !state_reg.pointer_zone_guard[PZ_ENABLE_POS] && state_reg.pointer_zone_guard[PZ_ALL_POS]
			|=> chk_done_out && chk_blocked_out)
		else $error("guard all did not block");
	a_guard_off: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R14]
		chk_valid_in && state_reg.pointer_zone_guard[PZ_ENABLE_POS] && state_reg.sector_lock[chk_sector]
			|=> !chk_blocked_out)
		else $error("disabled pointer zone still blocked");

	// named steps for reads, unlocks and pointer zone checks
	sequence s_no_read;
		!(cmd_in.valid && ((cmd_in.opcode == OP_LOCK_STATUS_READ) || (cmd_in.opcode == OP_READ_ANY_REG)
			|| (cmd_in.opcode == OP_SECTOR_LOCK_READ) || (cmd_in.opcode == OP_SECTOR_LOCK_READ_WIDE)));
	endsequence
	sequence s_sector_read;
		cmd_in.valid && ((cmd_in.opcode == OP_SECTOR_LOCK_READ) || (cmd_in.opcode == OP_SECTOR_LOCK_READ_WIDE));
	endsequence
	sequence s_sector_unlock;
		cmd_in.valid && ((cmd_in.opcode == OP_SECTOR_UNLOCK) || (cmd_in.opcode == OP_SECTOR_UNLOCK_WIDE));
	endsequence
	sequence s_zone_top;
		chk_valid_in && !state_reg.pointer_zone_guard[PZ_ENABLE_POS] && !state_reg.pointer_zone_guard[PZ_ALL_POS]
			&& !state_reg.pointer_zone_guard[PZ_DIRECTION_POS];
	endsequence
	sequence s_zone_bottom;
		chk_valid_in && !state_reg.pointer_zone_guard[PZ_ENABLE_POS] && !state_reg.pointer_zone_guard[PZ_ALL_POS]
			&& state_reg.pointer_zone_guard[PZ_DIRECTION_POS];
	endsequence

	// read answers: one pulse per read, no write path into lock status
	a_rd_single_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1] [R6]
		s_no_read |=> !rd_valid_out)
		else $error("read answer without a read");
	a_rdany_status: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1]
		cmd_in.valid && (cmd_in.opcode == OP_READ_ANY_REG) && (cmd_in.addr == ADDR_LOCK_STATUS)
			|=> rd_valid_out && (rd_data_out[31:8] == 24'h000000) && (rd_data_out[0] == $past(config_lock_out)))
		else $error("read any of lock status wrong");
	a_ls_no_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R1]
		cmd_in.valid && (cmd_in.opcode == OP_WRITE_ANY_REG) && (cmd_in.addr == ADDR_LOCK_STATUS)
			|=> $stable(config_lock_out))
		else $error("lock status took a write");

	// sector lock array follows lock and unlock commands
	a_sector_locked: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7]
		cmd_in.valid && ((cmd_in.opcode == OP_SECTOR_LOCK) || (cmd_in.opcode == OP_SECTOR_LOCK_WIDE))
			|=> !state_reg.sector_lock[$past(cmd_sector)])
		else $error("sector lock command missed");
	a_sector_opened: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R8]
		s_sector_unlock |=> state_reg.sector_lock[$past(cmd_sector)])
		else $error("sector unlock command missed");
	a_global_locked: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7]
		cmd_in.valid && (cmd_in.opcode == OP_GLOBAL_LOCK) |=> (state_reg.sector_lock == {SECTOR_COUNT{1'b0}}))
		else $error("global lock missed a sector");
	a_global_opened: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R8]
		cmd_in.valid && (cmd_in.opcode == OP_GLOBAL_UNLOCK) |=> (state_reg.sector_lock == {SECTOR_COUNT{1'b1}}))
		else $error("global unlock missed a sector");
	a_view_mirror: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R6]
		s_sector_read |=> rd_valid_out && (rd_data_out[31:8] == 24'h000000)
			&& (rd_data_out[7:0] == {8{$past(state_reg.sector_lock[cmd_sector])}}))
		else $error("sector view does not mirror the lock");

	// check port answers and the causes of blocking
	a_chk_answer: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7] [R8]
		chk_valid_in |=> chk_done_out)
		else $error("check not answered");
	a_locked_blocks: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R7]
		chk_valid_in && !state_reg.sector_lock[chk_sector] |=> chk_blocked_out)
		else $error("locked sector not blocked");
	a_top_inside: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
		s_zone_top ##0 (chk_page >= boundary) |=> chk_blocked_out)
		else $error("top zone page not blocked");
	a_top_outside: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
		s_zone_top ##0 ((chk_page < boundary) && state_reg.sector_lock[chk_sector]) |=> !chk_blocked_out)
		else $error("page below top zone blocked");
	a_bottom_inside: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
		s_zone_bottom ##0 (chk_page <= boundary) |=> chk_blocked_out)
		else $error("bottom zone page not blocked");
	a_bottom_outside: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R12]
		s_zone_bottom ##0 ((chk_page > boundary) && state_reg.sector_lock[chk_sector]) |=> !chk_blocked_out)
		else $error("page above bottom zone blocked");

	// narrow pointer set drops the upper address byte
	a_narrow_ptr: assert property (@(posedge clk_in) disable iff (!rstn_in) // [R10]
		cmd_in.valid && (cmd_in.opcode == OP_POINTER_SET) && config_lock_out
			|=> (state_reg.pointer_zone_guard[31:25] == 7'h00))
		else $error("narrow pointer set kept high bits");
endmodule

//--- rtl/flpls_pkg.sv
// constants and types for the flash protection and lock status block
package flpls_pkg;
	// command codes seen on the command port
	localparam logic [7:0] OP_LOCK_STATUS_READ = 8'hA7;
	localparam logic [7:0] OP_LOCK_STATUS_SET = 8'hA6;
	localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;
	localparam logic [7:0] OP_SECTOR_LOCK_READ = 8'h3D;
	localparam logic [7:0] OP_SECTOR_LOCK_READ_WIDE = 8'hE0;
	localparam logic [7:0] OP_SECTOR_LOCK = 8'h36;
	localparam logic [7:0] OP_SECTOR_LOCK_WIDE = 8'hE1;
	localparam logic [7:0] OP_SECTOR_UNLOCK = 8'h39;
	localparam logic [7:0] OP_SECTOR_UNLOCK_WIDE = 8'hE2;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_POINTER_SET = 8'hFB;
	localparam logic [7:0] OP_POINTER_SET_WIDE = 8'hE3;
	// register addresses for the generic read/write commands
	localparam logic [31:0] ADDR_LOCK_STATUS = 32'h0000_0040;
	localparam logic [31:0] ADDR_POINTER_ZONE = 32'h0000_0044;
	// lock status register fields
	localparam int LS_CONFIG_LOCK_POS = 0;
	localparam int LS_RD_PW_MODE_POS = 6;
	// otp guard configuration fields
	localparam int OTP_PERM_POS = 0;
	localparam int OTP_PASSWORD_POS = 2;
	localparam int OTP_BOOT_LOCK_POS = 4;
	localparam int OTP_RD_PW_POS = 6;
	// pointer zone register fields
	localparam int PZ_DIRECTION_POS = 9;
	localparam int PZ_ENABLE_POS = 10;
	localparam int PZ_ALL_POS = 11;
	localparam int PZ_ADDR_LO = 12;
	localparam int PZ_ADDR_HI = 24;
	localparam logic [31:0] PZ_RESET = 32'hFFFF_FFFF;
	// sector lock view values
	localparam logic [7:0] SECTOR_LOCKED = 8'h00;
	localparam logic [7:0] SECTOR_OPEN = 8'hFF;
	// sector array geometry
	localparam int SECTOR_COUNT = 512;
	localparam int SECTOR_SHIFT = 16;
	localparam int SECTOR_IDX_W = 9;
	localparam logic [31:0] NARROW_ADDR_MASK = 32'h00FF_FFFF;

	// command from the host controller
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [31:0] addr;
		logic [31:0] wdata;
	} flpls_cmd_type;

	// whole state of the block
	typedef struct packed {
		logic config_lock;
		logic [SECTOR_COUNT-1:0] sector_lock;
		logic [31:0] pointer_zone_guard;
		logic rd_valid;
		logic [31:0] rd_data;
		logic chk_done;
		logic chk_blocked;
	} flpls_state_type;
endpackage

//--- tb/flpls_host.sv
// host controller model issuing flash commands and protection checks
`timescale 1ns/1ps
module flpls_host
	import flpls_pkg::*;
(
	input wire logic clk_in,
	input wire logic rd_valid_in,
	input wire logic [31:0] rd_data_in,
	input wire logic chk_done_in,
	input wire logic chk_blocked_in,
	output flpls_cmd_type cmd_out,
	output logic chk_valid_out,
	output logic [31:0] chk_addr_out
);
	// idle bus at time zero
	initial begin
		cmd_out = '0;
		chk_valid_out = 1'b0;
		chk_addr_out = 32'h0000_0000;
	end
	// one command held over one edge; answer sampled after that edge
	task automatic send(input logic [7:0] op, input logic [31:0] addr, input logic [31:0] wd,
		output logic ok, output logic [31:0] rd);
		@(posedge clk_in);
		#1 cmd_out = {1'b1, op, addr, wd};
		@(posedge clk_in);
		#1 cmd_out = {1'b0, ~op, ~addr, ~wd}; // released fields stop showing the request
		ok = rd_valid_in;
		rd = rd_data_in;
	endtask
	// two commands on consecutive edges, answer of the second sampled
	task automatic pair(input logic [7:0] op1, input logic [31:0] addr1, input logic [7:0] op2,
		input logic [31:0] addr2, output logic ok, output logic [31:0] rd);
		@(posedge clk_in);
		#1 cmd_out = {1'b1, op1, addr1, 32'h0000_0000};
		@(posedge clk_in);
		#1 cmd_out = {1'b1, op2, addr2, 32'h0000_0000};
		@(posedge clk_in);
		#1 cmd_out = {1'b0, ~op2, ~addr2, 32'hFFFF_FFFF};
		ok = rd_valid_in;
		rd = rd_data_in;
	endtask
	// narrow opcode only while the address fits in 24 bits
	task automatic sector(input bit lock, input logic [31:0] addr);
		logic ok;
		logic [31:0] rd;
		if (addr[31:24] == 8'h00) send(lock ? OP_SECTOR_LOCK : OP_SECTOR_UNLOCK, addr, 32'h0, ok, rd);
		else send(lock ? OP_SECTOR_LOCK_WIDE : OP_SECTOR_UNLOCK_WIDE, addr, 32'h0, ok, rd);
	endtask
	// protection query, answer one cycle later
	task automatic check(input logic [31:0] addr, output logic done, output logic blk);
		@(posedge clk_in);
		#1 chk_valid_out = 1'b1;
		chk_addr_out = addr;
		@(posedge clk_in);
		#1 chk_valid_out = 1'b0;
		chk_addr_out = ~addr;
		done = chk_done_in;
		blk = chk_blocked_in;
	endtask
endmodule

//--- tb/tb_flpls_prot.sv
// self-checking bench for the flash protection and lock status block
`timescale 1ns/1ps
module tb_flpls_prot;
	import flpls_pkg::*;
	logic clk_in;
	logic rstn_in;
	logic [15:0] otp;
	flpls_cmd_type cmd;
	logic chk_valid, rd_valid, chk_done, chk_blocked, config_lock;
	logic [31:0] chk_addr, rd_data, a;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	flpls_prot u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd), .otp_guard_config_in(otp),
		.chk_valid_in(chk_valid), .chk_addr_in(chk_addr), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.chk_done_out(chk_done), .chk_blocked_out(chk_blocked), .config_lock_out(config_lock));
	flpls_host u_host (.clk_in(clk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data), .chk_done_in(chk_done),
		.chk_blocked_in(chk_blocked), .cmd_out(cmd), .chk_valid_out(chk_valid), .chk_addr_out(chk_addr));
	// shared compare
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] op, input logic [31:0] addr, input logic [31:0] exp);
		logic ok;
		logic [31:0] d;
		u_host.send(op, addr, 32'h0, ok, d);
		cmp({31'h0, ok}, 32'h1, "read answer");
		cmp(d, exp, "read data");
	endtask
	task automatic wr(input logic [7:0] op, input logic [31:0] addr, input logic [31:0] wd);
		logic ok;
		logic [31:0] d;
		u_host.send(op, addr, wd, ok, d);
	endtask
	// a command followed at once by a narrow sector lock read
	task automatic rd2(input logic [7:0] op1, input logic [31:0] a1, input logic [31:0] a2, input logic [31:0] exp);
		logic ok;
		logic [31:0] d;
		u_host.pair(op1, a1, OP_SECTOR_LOCK_READ, a2, ok, d);
		cmp({31'h0, ok}, 32'h1, "read answer");
		cmp(d, exp, "read data");
	endtask
	task automatic chk(input logic [31:0] addr, input logic exp);
		logic done;
		logic blk;
		u_host.check(addr, done, blk);
		cmp({31'h0, done}, 32'h1, "check answer");
		cmp({31'h0, blk}, {31'h0, exp}, "blocked");
	endtask
	task automatic rst(input logic [15:0] v);
		@(posedge clk_in);
		#1 rstn_in = 1'b0;
		otp = v;
		repeat (3) @(posedge clk_in);
		#1 rstn_in = 1'b1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			end_sim();
		end
	end
	// test sequence
	initial begin
		rstn_in = 1'b0;
		otp = 16'h0055;
		repeat (3) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		cmp({31'h0, config_lock}, 32'h1, "config lock");
		rd(OP_LOCK_STATUS_READ, 32'h0, 32'h41);
		rd(OP_READ_ANY_REG, ADDR_LOCK_STATUS, 32'h41);
		wr(OP_WRITE_ANY_REG, ADDR_LOCK_STATUS, 32'h0);
		rd(OP_LOCK_STATUS_READ, 32'h0, 32'h41);
		rd(OP_SECTOR_LOCK_READ, 32'h0012_0000, 32'h00);
		chk(32'h0012_3456, 1'b1);
		$display("test boot lock done");
		wr(OP_GLOBAL_UNLOCK, 32'h0, 32'h0);
		rd(OP_SECTOR_LOCK_READ_WIDE, 32'h01FF_0000, 32'hFF);
		chk(32'h0012_3456, 1'b0);
		for (int i = 0; i < 2; i++) begin
			a = i ? 32'h0134_0000 : 32'h0034_0000;
			u_host.sector(1'b1, a);
			rd(i ? OP_SECTOR_LOCK_READ_WIDE : OP_SECTOR_LOCK_READ, a, 32'h00);
			rd(OP_SECTOR_LOCK_READ_WIDE, a + 32'h0001_0000, 32'hFF);
			chk(a + 32'h0000_FFFF, 1'b1);
			u_host.sector(1'b0, a);
			rd(OP_SECTOR_LOCK_READ_WIDE, a, 32'hFF);
		end
		rd2(OP_SECTOR_LOCK, 32'h0022_0000, 32'h0022_0000, 32'h00);
		rd2(OP_GLOBAL_UNLOCK, 32'h0, 32'h0022_0000, 32'hFF);
		wr(OP_GLOBAL_LOCK, 32'h0, 32'h0);
		rd(OP_SECTOR_LOCK_READ, 32'h00AB_0000, 32'h00);
		wr(OP_GLOBAL_UNLOCK, 32'h0, 32'h0);
		$display("test sector locks done");
		wr(OP_POINTER_SET, 32'h01F0_0000, 32'h0);
		rd(OP_READ_ANY_REG, ADDR_POINTER_ZONE, 32'h00F0_0000);
		chk(32'h00F0_0000, 1'b1);
		chk(32'h00EF_FFFF, 1'b0);
		wr(OP_POINTER_SET_WIDE, 32'h00F0_0200, 32'h0);
		chk(32'h00F0_0FFF, 1'b1);
		chk(32'h00F0_1000, 1'b0);
		wr(OP_WRITE_ANY_REG, ADDR_POINTER_ZONE, 32'h0000_0A00);
		chk(32'h01FF_FFFF, 1'b1);
		wr(OP_WRITE_ANY_REG, ADDR_POINTER_ZONE, 32'h0000_0E00);
		chk(32'h01FF_FFFF, 1'b0);
		$display("test pointer zone done");
		rst(16'h0000);
		rd(OP_LOCK_STATUS_READ, 32'h0, 32'h00);
		rd(OP_SECTOR_LOCK_READ, 32'h0012_0000, 32'hFF);
		wr(OP_POINTER_SET, 32'h0000_0000, 32'h0);
		rd(OP_READ_ANY_REG, ADDR_POINTER_ZONE, PZ_RESET);
		wr(OP_WRITE_ANY_REG, ADDR_POINTER_ZONE, 32'h0);
		rd(OP_READ_ANY_REG, ADDR_POINTER_ZONE, PZ_RESET);
		wr(OP_LOCK_STATUS_SET, 32'h0, 32'h0);
		cmp({31'h0, config_lock}, 32'h1, "config lock");
		rd(OP_LOCK_STATUS_READ, 32'h0, 32'h01);
		rd(OP_READ_ANY_REG, 32'h0000_0048, 32'h0);
		$display("test config lock done");
		end_sim();
	end
endmodule
